/* kspp_params.svh */
// constants for the knock processor serial programming front end
// assumes inclusion by the package and the main module only
`ifndef KSPP_PARAMS_SVH
`define KSPP_PARAMS_SVH

`define KSPP_WORD_BITS        8
`define KSPP_SHIFT_CNT_W      4
`define KSPP_PULSES_PER_WORD  4'h8
`define KSPP_ADDR2_BANDPASS   2'h0
`define KSPP_ADDR2_PRESCALE   2'h1
`define KSPP_ADDR2_GAIN       2'h2
`define KSPP_ADDR3_TIMECONST  3'h6
`define KSPP_ADDR3_TESTCHAN   3'h7
`define KSPP_RST_CODE6        6'h00
`define KSPP_RST_CODE5        5'h00
`define KSPP_CLK_PERIOD_NS    100
`define KSPP_RESET_TIME_US    20
`define KSPP_RESET_CYCLES     ((`KSPP_RESET_TIME_US * 1000) / `KSPP_CLK_PERIOD_NS)
`define KSPP_RESET_CNT_W      8
`define KSPP_TEST_ANTIALIAS   4'h1

`endif

/* kspp_pkg.sv */
// types for the knock processor serial programming front end
// assumes kspp_params.svh is in the include path
`include "kspp_params.svh"

package kspp_pkg;
   typedef enum logic [1:0]
   {
      KSPP_IDLE  = 2'h0,
      KSPP_SHIFT = 2'h1,
      KSPP_DONE  = 2'h3,
      KSPP_BAD   = 2'h2
   } kspp_link_t;

   typedef enum logic [1:0]
   {
      KSPP_HOLD     = 2'h0,
      KSPP_RESETINT = 2'h1,
      KSPP_INTEG    = 2'h3
   } kspp_integ_t;
endpackage : kspp_pkg

/* kspp_sync.sv */
// two-flop synchroniser bank for asynchronous pin inputs
// assumes one system clock; the first stage feeds only the second
`timescale 1ns/10ps
`default_nettype none

module kspp_sync
#(
   parameter int WIDTH = 4
)
(
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rstn,
   // data
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : g_bit
         always_ff @(posedge sys_clk or negedge rstn)
         begin
            if (!rstn)
            begin
               meta[i]     <= 1'b0;
               sync_out[i] <= 1'b0;
            end
            else
            begin
               meta[i]     <= async_in[i];
               sync_out[i] <= meta[i];
            end
         end
      end
   endgenerate

endmodule : kspp_sync

`default_nettype wire

/* kspp_core.sv */
// serial programming front end of an engine knock signal processor
// assumes pins arrive unsynchronised and sck is far slower than sys_clk
//
// Contract
// RL1: after chip select falls, sample serial input on each serial clock falling edge
// RL2: words arrive most significant bit first and are assembled in that order
// RL3: split each word into a 2 or 3 bit address and a 6 or 5 bit value
// RL4: address 00 stores six value bits as bandpass centre code
// RL5: address 10 stores six value bits as gain code
// RL6: address 110 stores five value bits as integrator time code
// RL7: address 111 writes test/channel; lowest bit chooses input channel 0 or 1
// RL8: four diagnostic bits act only while test pin is low, never in run mode
// RL9: address 01 writes prescaler; four divider bits used, top divider bit ignored
// RL10: last prescaler word bit three-states serial output; all zero means driven
// RL11: all five words are accepted while integrate/hold is low
// RL12: integrate/hold rising starts integration after integrator reset within 20 us
// RL13: six-bit gain code selects one of 64 gains
// RL14: six-bit bandpass code selects one of 64 centre frequencies
// RL15: five-bit time code selects one of 32 time constants
// RL16: antialias evaluation mode powers down the output buffer amplifier
// RL17: host holds clock low before select falls, sends exactly 8 pulses ending low
// RL18: on chip select rising after a valid sequence, load the addressed register
// RL19: registers keep values until rewritten and clear to zero at reset
`timescale 1ns/10ps
`default_nettype none
`include "kspp_params.svh"

module kspp_core
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   // serial programming pins
   input  wire logic       cs_n,
   input  wire logic       sck,
   input  wire logic       si,
   output logic            so_out,
   output logic            so_oe,
   // integrate/hold and test pins
   input  wire logic       int_hold,
   input  wire logic       test_pin,
   // analog control outputs
   output logic [5:0]      bandpass_center_code,
   output logic [5:0]      gain_setting_code,
   output logic [4:0]      integrator_time_code,
   output logic            input_channel_bit,
   output logic [3:0]      diag_mode,
   output logic [3:0]      clock_divider_bits,
   output logic            unused_divider_bit,
   output logic            so_tristate,
   output logic            out_buffer_powerdown,
   output logic            integrator_reset,
   output logic            integrate_active,
   output logic            word_loaded
);

   logic [3:0]                    pins_sync;
   logic                          cs_s;
   logic                          sck_s;
   logic                          si_s;
   logic                          ih_s;
   logic                          cs_d;
   logic                          sck_d;
   logic                          ih_d;
   logic                          sck_fall;
   logic                          sck_rise;
   logic                          cs_fall;
   logic                          cs_rise;
   logic                          ih_rise;
   kspp_pkg::kspp_link_t          link_state;
   logic [`KSPP_WORD_BITS-1:0]    shift_word;
   logic [`KSPP_SHIFT_CNT_W-1:0]  pulse_cnt;
   logic                          word_ok;
   kspp_pkg::kspp_integ_t         integ_state;
   logic [`KSPP_RESET_CNT_W-1:0]  reset_cnt;
   logic [3:0]                    diag_bits;
   logic                          so_last;

   localparam logic [`KSPP_RESET_CNT_W-1:0] RESET_LAST =
      `KSPP_RESET_CNT_W'(`KSPP_RESET_CYCLES - 1);

   // pins are asynchronous to sys_clk
   // select enters inverted so the zero reset of the synchroniser equals its idle level, avoiding a false edge
   kspp_sync #(.WIDTH(4)) u_sync
   (
      .sys_clk  (sys_clk),
      .rstn     (rstn),
      .async_in ({int_hold, si, sck, ~cs_n}),
      .sync_out (pins_sync)
   );

   assign cs_s  = ~pins_sync[0];
   assign sck_s = pins_sync[1];
   assign si_s  = pins_sync[2];
   assign ih_s  = pins_sync[3];

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cs_d  <= 1'b1;
         sck_d <= 1'b0;
         ih_d  <= 1'b0;
      end
      else
      begin
         cs_d  <= cs_s;
         sck_d <= sck_s;
         ih_d  <= ih_s;
      end
   end

   assign sck_fall = sck_d & ~sck_s;
   assign sck_rise = ~sck_d & sck_s;
   assign cs_fall  = cs_d & ~cs_s;
   assign cs_rise  = ~cs_d & cs_s;
   assign ih_rise  = ~ih_d & ih_s;

   // link filter: clock must be low at select fall, eight pulses, ending low
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         link_state <= kspp_pkg::KSPP_IDLE;
      end
      else
      begin
         case (link_state)
            kspp_pkg::KSPP_IDLE:
            begin
               if (cs_fall)
                  link_state <= sck_s ? kspp_pkg::KSPP_BAD : kspp_pkg::KSPP_SHIFT; // RL17
            end
            kspp_pkg::KSPP_SHIFT:
            begin
               if (cs_rise)
                  link_state <= kspp_pkg::KSPP_IDLE;
               else if (sck_fall && pulse_cnt == `KSPP_PULSES_PER_WORD - 4'h1)
                  link_state <= kspp_pkg::KSPP_DONE;
            end
            kspp_pkg::KSPP_DONE:
            begin
               // a ninth edge spoils the word
               if (cs_rise)
                  link_state <= kspp_pkg::KSPP_IDLE;
               else if (sck_rise)
                  link_state <= kspp_pkg::KSPP_BAD; // RL17
            end
            kspp_pkg::KSPP_BAD:
            begin
               if (cs_rise)
                  link_state <= kspp_pkg::KSPP_IDLE;
            end
            default:
            begin
               link_state <= kspp_pkg::KSPP_IDLE;
            end
         endcase
      end
   end

   // msb first shift on each falling clock edge
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         shift_word <= `KSPP_WORD_BITS'(0);
         pulse_cnt  <= `KSPP_SHIFT_CNT_W'(0);
      end
      else if (link_state == kspp_pkg::KSPP_IDLE)
      begin
         pulse_cnt <= `KSPP_SHIFT_CNT_W'(0);
      end
      else if (link_state == kspp_pkg::KSPP_SHIFT && sck_fall)
      begin
         shift_word <= {shift_word[`KSPP_WORD_BITS-2:0], si_s}; // RL1 RL2
         pulse_cnt  <= pulse_cnt + `KSPP_SHIFT_CNT_W'(1);
      end
   end

   // a word counts only if it ended low after exactly eight pulses
   assign word_ok = (link_state == kspp_pkg::KSPP_DONE) && cs_rise && !sck_s; // RL18

   // decode on select rising; works in hold and in integrate alike
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         bandpass_center_code <= `KSPP_RST_CODE6; // RL19
         gain_setting_code    <= `KSPP_RST_CODE6;
         integrator_time_code <= `KSPP_RST_CODE5;
         input_channel_bit    <= 1'b0;
         diag_bits            <= 4'h0;
         clock_divider_bits   <= 4'h0;
         unused_divider_bit   <= 1'b0;
         so_tristate          <= 1'b0;
      end
      else if (word_ok) // RL11
      begin
         case (shift_word[7:6]) // RL3
            `KSPP_ADDR2_BANDPASS: bandpass_center_code <= shift_word[5:0]; // RL4 RL14
            `KSPP_ADDR2_GAIN:     gain_setting_code    <= shift_word[5:0]; // RL5 RL13
            `KSPP_ADDR2_PRESCALE:
            begin
               unused_divider_bit <= shift_word[5]; // RL9
               clock_divider_bits <= shift_word[4:1]; // RL9
               so_tristate        <= shift_word[0]; // RL10
            end
            default:
            begin
               if (shift_word[7:5] == `KSPP_ADDR3_TIMECONST)
                  integrator_time_code <= shift_word[4:0]; // RL6 RL15
               else
               begin
                  diag_bits         <= shift_word[4:1]; // RL8
                  input_channel_bit <= shift_word[0]; // RL7
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         word_loaded <= 1'b0;
      else
         word_loaded <= word_ok;
   end

   // diagnostics gated off in run mode (test pin high)
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         diag_mode <= 4'h0;
      else
         diag_mode <= test_pin ? 4'h0 : diag_bits; // RL8
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         out_buffer_powerdown <= 1'b0;
      else
         out_buffer_powerdown <= !test_pin && (diag_bits == `KSPP_TEST_ANTIALIAS); // RL16
   end

   // integrator: reset phase on rising int_hold, then accumulate
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         integ_state <= kspp_pkg::KSPP_HOLD;
         reset_cnt   <= `KSPP_RESET_CNT_W'(0);
      end
      else
      begin
         case (integ_state)
            kspp_pkg::KSPP_HOLD:
            begin
               reset_cnt <= `KSPP_RESET_CNT_W'(0);
               if (ih_rise)
                  integ_state <= kspp_pkg::KSPP_RESETINT; // RL12
            end
            kspp_pkg::KSPP_RESETINT:
            begin
               reset_cnt <= reset_cnt + `KSPP_RESET_CNT_W'(1);
               if (!ih_s)
                  integ_state <= kspp_pkg::KSPP_HOLD;
               else if (reset_cnt == RESET_LAST)
                  integ_state <= kspp_pkg::KSPP_INTEG; // RL12
            end
            kspp_pkg::KSPP_INTEG:
            begin
               if (!ih_s)
                  integ_state <= kspp_pkg::KSPP_HOLD;
            end
            default:
            begin
               integ_state <= kspp_pkg::KSPP_HOLD;
            end
         endcase
      end
   end

   assign integrator_reset = (integ_state == kspp_pkg::KSPP_RESETINT);
   assign integrate_active = (integ_state == kspp_pkg::KSPP_INTEG);

   // serial output: buffered serial input, driven unless three-stated
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         so_last <= 1'b0;
      else
         so_last <= si_s;
   end

   assign so_out = so_last;
   assign so_oe  = ~so_tristate; // RL10

   // checks
   sequence s_good_word;
      (link_state == kspp_pkg::KSPP_DONE) && cs_rise && !sck_s;
   endsequence

   load_pulse_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL18
      s_good_word |=> word_loaded)
      else $error("valid word not loaded");

   gain_store_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL5
      s_good_word and (shift_word[7:6] == 2'h2) |=> gain_setting_code == $past(shift_word[5:0]))
      else $error("gain code not stored");

   band_store_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL4
      s_good_word and (shift_word[7:6] == 2'h0) |=> bandpass_center_code == $past(shift_word[5:0]))
      else $error("bandpass code not stored");

   time_store_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL6
      s_good_word and (shift_word[7:5] == 3'h6) |=> integrator_time_code == $past(shift_word[4:0]))
      else $error("time code not stored");

   chan_store_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL7
      s_good_word and (shift_word[7:5] == 3'h7) |=> input_channel_bit == $past(shift_word[0]))
      else $error("channel bit not stored");

   so_drive_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL10
      s_good_word and (shift_word[7:6] == 2'h1) |=> so_oe == !$past(shift_word[0]))
      else $error("so enable wrong");

   bad_word_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL17
      (link_state == kspp_pkg::KSPP_BAD) |=> !word_loaded)
      else $error("bad word loaded");

   shift_msb_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL1
      (link_state == kspp_pkg::KSPP_SHIFT) && sck_fall |=> shift_word[0] == $past(si_s))
      else $error("serial bit not captured");

   run_mode_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL8
      test_pin |=> diag_mode == 4'h0)
      else $error("diagnostics active in run mode");

   integ_rst_a: assert property (@(posedge sys_clk) disable iff (!rstn) // RL12
      ih_rise ##1 ih_s [*2] |-> ##[1:200] integrate_active || !ih_s)
      else $error("integrator reset too long");

endmodule : kspp_core

`default_nettype wire

/* kspp_host.sv */
// host processor model driving the serial programming pins
// assumes tb calls its tasks just after a rising sys_clk edge
`timescale 1ns/10ps
`default_nettype none

module kspp_host
(
   // clock
   input  wire logic sys_clk,
   // serial programming pins
   output var  logic cs_n,
   output var  logic sck,
   output var  logic si
);
   initial
   begin
      cs_n = 1'b1;
      sck  = 1'b0;
      si   = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n)
      begin
         @(posedge sys_clk);
         #1;
      end
   endtask : tick

   // half sets each clock level in sys_clk cycles, 3 at least
   task automatic frame(input logic [7:0] w, input int pulses, input logic sck_hi, input int half);
      logic [7:0] sh;
      sh  = w;
      sck = sck_hi;
      tick(half);
      cs_n = 1'b0;
      tick(half);
      repeat (pulses)
      begin
         si  = sh[7];
         sh  = {sh[6:0], sh[7]};
         sck = 1'b1;
         tick(half);
         sck = 1'b0;
         tick(half);
      end
   endtask : frame

   // a released data line shows the inverse, never the held bit
   task automatic finish_frame;
      cs_n = 1'b1;
      si   = ~si;
   endtask : finish_frame
endmodule : kspp_host
`default_nettype wire

/* tb.sv */
// self-checking bench for the serial programming front end
// assumes kspp_core and kspp_host are compiled first
`timescale 1ns/10ps
`default_nettype none

module tb;
   typedef struct packed
   {
      logic [7:0] w;
      logic [5:0] bp;
      logic [5:0] gn;
      logic [4:0] tc;
      logic [4:0] ts;
      logic [5:0] pr;
   } kspp_row_t;

   logic       sys_clk, rstn, int_hold, test_pin;
   wire logic  cs_n, sck, si;
   logic       so_out, so_oe, input_channel_bit, unused_divider_bit, so_tristate;
   logic       out_buffer_powerdown, integrator_reset, integrate_active, word_loaded;
   logic [5:0] bandpass_center_code, gain_setting_code;
   logic [4:0] integrator_time_code;
   logic [3:0] diag_mode, clock_divider_bits;
   int         errors, checked, n;
   kspp_row_t  z;
   int         np [3] = '{7, 9, 8};
   logic       hi [3] = '{1'b0, 1'b0, 1'b1};
   kspp_row_t  rows [12] = '{
      '{8'h0a, 6'h0a, 6'h00, 5'h00, 5'h00, 6'h00},
      '{8'h94, 6'h0a, 6'h14, 5'h00, 5'h00, 6'h00},
      '{8'hc3, 6'h0a, 6'h14, 5'h03, 5'h00, 6'h00},
      '{8'he1, 6'h0a, 6'h14, 5'h03, 5'h01, 6'h00},
      '{8'h7f, 6'h0a, 6'h14, 5'h03, 5'h01, 6'h3f},
      '{8'h5e, 6'h0a, 6'h14, 5'h03, 5'h01, 6'h1e},
      '{8'h40, 6'h0a, 6'h14, 5'h03, 5'h01, 6'h00},
      '{8'h3f, 6'h3f, 6'h14, 5'h03, 5'h01, 6'h00},
      '{8'hbf, 6'h3f, 6'h3f, 5'h03, 5'h01, 6'h00},
      '{8'hdf, 6'h3f, 6'h3f, 5'h1f, 5'h01, 6'h00},
      '{8'hf2, 6'h3f, 6'h3f, 5'h1f, 5'h12, 6'h00},
      '{8'he2, 6'h3f, 6'h3f, 5'h1f, 5'h02, 6'h00}};

   kspp_host i_host (.sys_clk(sys_clk), .cs_n(cs_n), .sck(sck), .si(si));

   kspp_core i_kspp_core (.sys_clk(sys_clk), .rstn(rstn), .cs_n(cs_n), .sck(sck), .si(si),
      .so_out(so_out), .so_oe(so_oe), .int_hold(int_hold), .test_pin(test_pin),
      .bandpass_center_code(bandpass_center_code), .gain_setting_code(gain_setting_code),
      .integrator_time_code(integrator_time_code), .input_channel_bit(input_channel_bit),
      .diag_mode(diag_mode), .clock_divider_bits(clock_divider_bits),
      .unused_divider_bit(unused_divider_bit), .so_tristate(so_tristate),
      .out_buffer_powerdown(out_buffer_powerdown), .integrator_reset(integrator_reset),
      .integrate_active(integrate_active), .word_loaded(word_loaded));

   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic stop_test;
      if (errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : stop_test

   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic check_regs(input kspp_row_t r);
      logic [3:0] d;
      d = test_pin ? 4'h0 : r.ts[4:1];
      chk("bandpass", r.bp, bandpass_center_code);
      chk("gain", r.gn, gain_setting_code);
      chk("time", r.tc, integrator_time_code);
      chk("channel", r.ts[0], input_channel_bit);
      chk("diag", d, diag_mode);
      chk("prescale", r.pr, {unused_divider_bit, clock_divider_bits, so_tristate});
      chk("so_oe", !r.pr[0], so_oe);
      chk("powerdown", d == 4'h1, out_buffer_powerdown);
      chk("so_out", {7'h0, si}, {7'h0, so_out});
   endtask : check_regs

   task automatic wait_loaded;
      n = 0;
      while (word_loaded !== 1'b1 && n < 20)
      begin
         i_host.tick(1);
         n++;
      end
      chk("loaded", 8'h01, {7'h0, word_loaded});
      // registered diagnostic outputs follow the load pulse by one cycle
      i_host.tick(1);
   endtask : wait_loaded

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      stop_test();
   end

   initial
   begin
      errors   = 0;
      checked  = 0;
      z        = '0;
      rstn     = 1'b0;
      int_hold = 1'b0;
      test_pin = 1'b0;
      repeat (16) @(posedge sys_clk);
      #1 rstn = ~rstn;
      i_host.tick(4);
      check_regs(z);
      foreach (rows[i])
      begin
         // odd rows use a slow host
         i_host.frame(rows[i].w, 8, 1'b0, (i % 2) ? 7 : 4);
         i_host.finish_frame();
         wait_loaded();
         check_regs(rows[i]);
      end
      test_pin = ~test_pin;
      i_host.tick(3);
      check_regs(rows[11]);
      test_pin = ~test_pin;
      i_host.tick(3);
      check_regs(rows[11]);
      // word must stay buffered until select rises
      i_host.frame(8'h15, 8, 1'b0, 4);
      i_host.tick(10);
      chk("early", 8'h3f, bandpass_center_code);
      i_host.finish_frame();
      wait_loaded();
      chk("late", 8'h15, bandpass_center_code);
      foreach (np[k])
      begin
         i_host.frame(8'h00, np[k], hi[k], 4);
         i_host.finish_frame();
         i_host.tick(12);
         chk("refused", 8'h15, bandpass_center_code);
      end
      int_hold = ~int_hold;
      n = 0;
      while (integrator_reset !== 1'b1 && n < 10)
      begin
         i_host.tick(1);
         n++;
      end
      n = 0;
      while (integrator_reset === 1'b1 && n < 300)
      begin
         i_host.tick(1);
         n++;
      end
      chk("reset_len", 8'hc8, n[7:0]);
      chk("integrate", 8'h01, {7'h0, integrate_active});
      int_hold = ~int_hold;
      i_host.tick(4);
      chk("hold", 8'h00, {7'h0, integrate_active});
      rstn = ~rstn;
      i_host.tick(2);
      rstn = ~rstn;
      i_host.tick(4);
      check_regs(z);
      stop_test();
   end
endmodule : tb
`default_nettype wire
